// >>> src/spd_pkg.sv
// Constants and latch layouts for the serial PLL divider control block.
package spd_pkg;

  // ----------------------------------------
  // Field widths
  // ----------------------------------------
  localparam int REF_W = 14;
  localparam int MAIN_W = 11;
  localparam int SWAL_W = 7;
  localparam int SHIFT_W = 19;
  localparam int PRE_W = 7;
  localparam int SYNC_W = 3;

  // ----------------------------------------
  // Bit positions in the shift register
  // ----------------------------------------
  localparam int CTRL_BIT = 0;
  localparam int REF_LSB = 1;
  localparam int REF_MSB = 15;
  localparam int DIV_LSB = 1;
  localparam int DIV_MSB = 18;

  // ----------------------------------------
  // Synchroniser lanes
  // ----------------------------------------
  localparam int SY_LOAD = 0;
  localparam int SY_POL = 1;
  localparam int SY_VCO = 2;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [13:0] REF_RATIO_RST = 14'h0008;
  localparam logic [10:0] MAIN_RATIO_RST = 11'h010;
  localparam logic [6:0] SWAL_RST = 7'h00;
  localparam logic MOD_SEL_RST = 1'b1;

  // ----------------------------------------
  // Prescaler moduli
  // ----------------------------------------
  localparam logic [6:0] MOD_SMALL = 7'h20;
  localparam logic [6:0] MOD_LARGE = 7'h40;

  // ----------------------------------------
  // Latch layouts
  // ----------------------------------------
  typedef struct packed {
    logic modulus_sel;
    logic [REF_W-1:0] ratio;
  } spd_ref_latch_t;

  typedef struct packed {
    logic [MAIN_W-1:0] main_ratio;
    logic [SWAL_W-1:0] swallow;
  } spd_div_latch_t;

endpackage : spd_pkg

// >>> src/spd_serial_pll_divider.sv
// Digital core of a serially programmed PLL synthesizer with pulse swallow.
//
// What this block does
// (R1) Each serial clock rising edge shifts the data input into the shift register.
// (R2) While the load strobe is high, shift contents go to the selected latch.
// (R3) Control bit one loads the reference latch; zero loads the divider latch.
// (R4) Host sends reference word: modulus select, ratio 14..1, control bit last.
// (R5) Reference counter divides the oscillator by a 14-bit ratio, 8 to 16383.
// (R6) Modulus select high picks 32/33, low picks 64/65.
// (R7) Host sends divider word: main 18..8, swallow 7..1, control zero last.
// (R8) Swallow count is 0 to 63; host keeps its top bit zero.
// (R9) Main counter divides by an 11-bit ratio, 16 to 2047.
// (R10) Host keeps swallow count below the main ratio.
// (R11) Each comparison cycle spans modulus times main ratio plus swallow VCO cycles.
// (R12) Polarity high: reference faster pumps high, VCO faster pumps low, equal floats.
// (R13) Polarity low inverts the detector sense; equal phases still float the pump.
// (R14) Monitor shows divided reference when polarity high, divided VCO when low.
// (R15) System sets polarity to match the VCO tuning slope.
// (R16) Detector covers plus and minus two pi and emits short pulses near lock.
// (R17) Fast-lock switch passes the pump state while strobe high, else floats.
// (R18) Host raises the load strobe only while loading a new ratio.
// (R19) Lock indicator is high and drops whenever a phase difference exists.
// (R20) VCO-side pump output is an open-drain pull-down, driving low or released.
// (R21) Counters reload from latches at terminal count only.
`timescale 1ns/1ps
`default_nettype none

module spd_serial_pll_divider (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_latch_strobe,
  input wire logic phase_polarity_select,
  input wire logic vco_in,
  output var logic pump_out,
  output var logic pump_oe,
  output var logic ref_pd_out,
  output var logic vco_pd_out,
  output var logic vco_pd_oe,
  output var logic fastlock_switch_out,
  output var logic fastlock_switch_oe,
  output var logic lock_indicator_out,
  output var logic monitor_out
);

  // ----------------------------------------
  // Serial link domain
  // ----------------------------------------
  logic [spd_pkg::SHIFT_W-1:0] shift_reg;

  // (R1) Shift on edge
  always_ff @(posedge ser_clk)
  begin
    shift_reg <= {shift_reg[spd_pkg::SHIFT_W-2:0], ser_data};
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [spd_pkg::SYNC_W-1:0] sync1_reg;
  logic [spd_pkg::SYNC_W-1:0] sync2_reg;
  logic vco_prev_reg;
  wire logic [spd_pkg::SYNC_W-1:0] pins_w;

  assign pins_w = {vco_in, phase_polarity_select, load_latch_strobe};

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      vco_prev_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_reg <= pins_w;
      sync2_reg <= sync1_reg;
      vco_prev_reg <= sync2_reg[spd_pkg::SY_VCO];
    end
  end

  wire logic load_s;
  wire logic pol_s;
  wire logic vco_edge;

  assign load_s = sync2_reg[spd_pkg::SY_LOAD];
  assign pol_s = sync2_reg[spd_pkg::SY_POL];
  assign vco_edge = sync2_reg[spd_pkg::SY_VCO] & ~vco_prev_reg;

  // ----------------------------------------
  // Latches
  // ----------------------------------------
  // The shift register is read here only while the synchronised strobe is
  // high. The host leaves the serial clock still while the strobe is up, so
  // the word is static by the time the strobe has crossed two flip-flops.
  spd_pkg::spd_ref_latch_t ref_lat_reg;
  spd_pkg::spd_div_latch_t div_lat_reg;
  wire logic load_ref;
  wire logic load_div;

  // (R3) Control bit routing
  assign load_ref = load_s & shift_reg[spd_pkg::CTRL_BIT];
  assign load_div = load_s & ~shift_reg[spd_pkg::CTRL_BIT];

  // (R2) Transfer while strobe high
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ref_lat_reg <= {spd_pkg::MOD_SEL_RST, spd_pkg::REF_RATIO_RST};
      div_lat_reg <= {spd_pkg::MAIN_RATIO_RST, spd_pkg::SWAL_RST};
    end
    else if (clk_en)
    begin
      if (load_ref)
      begin
        ref_lat_reg <= shift_reg[spd_pkg::REF_MSB:spd_pkg::REF_LSB];
      end
      if (load_div)
      begin
        div_lat_reg <= shift_reg[spd_pkg::DIV_MSB:spd_pkg::DIV_LSB];
      end
    end
  end

  // ----------------------------------------
  // Reference counter
  // ----------------------------------------
  logic [spd_pkg::REF_W-1:0] ref_cnt_reg;
  wire logic ref_tc;
  wire logic [spd_pkg::REF_W-1:0] ref_cnt_next;

  // (R5) Divide by reference ratio
  assign ref_tc = (ref_cnt_reg == '0);
  // (R21) Reload at terminal count
  assign ref_cnt_next = ref_tc ? spd_pkg::REF_W'(ref_lat_reg.ratio - 1'b1)
                               : spd_pkg::REF_W'(ref_cnt_reg - 1'b1);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ref_cnt_reg <= spd_pkg::REF_W'(spd_pkg::REF_RATIO_RST - 1'b1);
    end
    else if (clk_en)
    begin
      ref_cnt_reg <= ref_cnt_next;
    end
  end

  // ----------------------------------------
  // Prescaler, swallow and main counters
  // ----------------------------------------
  logic [spd_pkg::PRE_W-1:0] pre_cnt_reg;
  logic [spd_pkg::SWAL_W-1:0] a_cnt_reg;
  logic [spd_pkg::MAIN_W-1:0] n_cnt_reg;
  logic mod_sel_reg;
  wire logic pre_tc;
  wire logic n_tc;
  wire logic [spd_pkg::SWAL_W-1:0] a_next;
  wire logic [spd_pkg::MAIN_W-1:0] n_next;
  wire logic mod_sel_next;
  wire logic [spd_pkg::PRE_W-1:0] pre_base;
  wire logic [spd_pkg::PRE_W-1:0] pre_load;

  assign pre_tc = vco_edge & (pre_cnt_reg == '0);
  assign n_tc = (n_cnt_reg == '0);

  // (R9) Main counter ratio
  // (R21) Reload at terminal count
  assign n_next = n_tc ? spd_pkg::MAIN_W'(div_lat_reg.main_ratio - 1'b1)
                       : spd_pkg::MAIN_W'(n_cnt_reg - 1'b1);
  assign a_next = n_tc ? div_lat_reg.swallow
                : (a_cnt_reg != '0) ? spd_pkg::SWAL_W'(a_cnt_reg - 1'b1)
                : a_cnt_reg;
  assign mod_sel_next = n_tc ? ref_lat_reg.modulus_sel : mod_sel_reg;

  // (R6) Modulus pair select
  assign pre_base = mod_sel_next ? spd_pkg::MOD_SMALL : spd_pkg::MOD_LARGE;
  // (R11) Extra count while swallowing
  assign pre_load = (a_next != '0) ? pre_base
                                   : spd_pkg::PRE_W'(pre_base - 1'b1);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pre_cnt_reg <= spd_pkg::PRE_W'(spd_pkg::MOD_SMALL - 1'b1);
      a_cnt_reg <= spd_pkg::SWAL_RST;
      n_cnt_reg <= spd_pkg::MAIN_W'(spd_pkg::MAIN_RATIO_RST - 1'b1);
      mod_sel_reg <= spd_pkg::MOD_SEL_RST;
    end
    else if (clk_en)
    begin
      if (pre_tc)
      begin
        pre_cnt_reg <= pre_load;
        a_cnt_reg <= a_next;
        n_cnt_reg <= n_next;
        mod_sel_reg <= mod_sel_next;
      end
      else if (vco_edge)
      begin
        pre_cnt_reg <= spd_pkg::PRE_W'(pre_cnt_reg - 1'b1);
      end
    end
  end

  wire logic fr_pulse;
  wire logic fp_pulse;

  assign fr_pulse = ref_tc;
  assign fp_pulse = pre_tc & n_tc;

  // ----------------------------------------
  // Phase-frequency detector
  // ----------------------------------------
  // Both flags high for one cycle before clearing; lead and lag exclude that
  // cycle, so the pump floats and the lock indicator stays high during it.
  logic up_reg;
  logic dn_reg;
  wire logic both;
  wire logic up_next;
  wire logic dn_next;

  assign both = up_reg & dn_reg;
  // (R16) Two pi range, spikes
  assign up_next = both ? fr_pulse : (up_reg | fr_pulse);
  assign dn_next = both ? fp_pulse : (dn_reg | fp_pulse);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      up_reg <= up_next;
      dn_reg <= dn_next;
    end
  end

  // ----------------------------------------
  // Output decode
  // ----------------------------------------
  wire logic lead;
  wire logic lag;
  wire logic eff_up;
  wire logic eff_dn;
  wire logic pump_oe_next;
  wire logic lock_next;
  wire logic monitor_next;

  assign lead = up_reg & ~dn_reg;
  assign lag = dn_reg & ~up_reg;
  // (R12) Normal sense
  // (R13) Inverted sense
  assign eff_up = pol_s ? lead : lag;
  assign eff_dn = pol_s ? lag : lead;
  assign pump_oe_next = eff_up | eff_dn;
  // (R19) Lock indicator
  assign lock_next = ~(lead | lag);
  // (R14) Monitor select
  assign monitor_next = pol_s ? fr_pulse : fp_pulse;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pump_out <= 1'b0;
      pump_oe <= 1'b0;
      ref_pd_out <= 1'b0;
      vco_pd_out <= 1'b0;
      vco_pd_oe <= 1'b0;
      fastlock_switch_out <= 1'b0;
      fastlock_switch_oe <= 1'b0;
      lock_indicator_out <= 1'b1;
      monitor_out <= 1'b0;
    end
    else if (clk_en)
    begin
      pump_out <= eff_up;
      pump_oe <= pump_oe_next;
      ref_pd_out <= eff_dn;
      // (R20) Open-drain pull-down
      vco_pd_out <= 1'b0;
      vco_pd_oe <= eff_up;
      // (R17) Fast-lock switch
      fastlock_switch_out <= load_s & eff_up;
      fastlock_switch_oe <= load_s & pump_oe_next;
      lock_indicator_out <= lock_next;
      monitor_out <= monitor_next;
    end
  end

endmodule : spd_serial_pll_divider

`default_nettype wire

// >>> verification/spd_monitor.sv
// Checker on the divider control ports.
`timescale 1ns/1ps
`default_nettype none
module spd_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load_latch_strobe,
  input wire logic pump_out,
  input wire logic pump_oe,
  input wire logic ref_pd_out,
  input wire logic vco_pd_out,
  input wire logic vco_pd_oe,
  input wire logic fastlock_switch_out,
  input wire logic fastlock_switch_oe,
  input wire logic lock_indicator_out,
  input wire logic monitor_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_reset_state: assert property (disable iff (1'b0) sys_rst |=> lock_indicator_out && !pump_oe)
    else $error("reset state");
  a_open_drain: assert property (!vco_pd_out)
    else $error("drain high");
  a_equal_idle: assert property (lock_indicator_out |-> !pump_oe && !vco_pd_oe && !ref_pd_out)
    else $error("idle outputs");
  a_lock_drop: assert property (!lock_indicator_out |-> pump_oe)
    else $error("lock without pump");
  a_pump_sense: assert property (pump_oe |-> vco_pd_oe == pump_out && ref_pd_out == !pump_out)
    else $error("pump sides");
  // Six cycles cover the strobe synchroniser and the output register.
  a_switch_on: assert property (load_latch_strobe [*6] |-> fastlock_switch_oe == pump_oe)
    else $error("switch on");
  a_switch_level: assert property (fastlock_switch_oe |-> fastlock_switch_out == pump_out)
    else $error("switch level");
  a_switch_off: assert property (!load_latch_strobe [*6] |-> !fastlock_switch_oe)
    else $error("switch off");
  a_mon_pulse: assert property (monitor_out |=> !monitor_out)
    else $error("monitor width");
  c_up: cover property (pump_oe && pump_out);
  c_down: cover property (pump_oe && !pump_out);
  c_switch: cover property (fastlock_switch_oe && pump_oe);
endmodule : spd_monitor
bind spd_serial_pll_divider spd_monitor u_mon (
  .clk(clk), .sys_rst(sys_rst), .load_latch_strobe(load_latch_strobe),
  .pump_out(pump_out), .pump_oe(pump_oe), .ref_pd_out(ref_pd_out),
  .vco_pd_out(vco_pd_out), .vco_pd_oe(vco_pd_oe),
  .fastlock_switch_out(fastlock_switch_out), .fastlock_switch_oe(fastlock_switch_oe),
  .lock_indicator_out(lock_indicator_out), .monitor_out(monitor_out)
);
`default_nettype wire

// >>> verification/spd_host_model.sv
// Host model driving the serial programming link.
`timescale 1ns/1ps
`default_nettype none
module spd_host_model (
  input wire logic clk,
  output var logic ser_clk,
  output var logic ser_data,
  output var logic load_latch_strobe
);
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_latch_strobe = 1'b0;
  end
  task automatic put(input logic b);
    ser_data = b;
    #7.5 ser_clk = 1'b1;
    #7.5 ser_clk = 1'b0;
  endtask : put
  task automatic load(input logic last);
    // The line floats between words, so the model shows the opposite bit.
    ser_data = ~last;
    @(posedge clk);
    load_latch_strobe <= 1'b1;
    repeat (8) @(posedge clk);
    load_latch_strobe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : load
  task automatic send_ref(input logic sw, input logic [13:0] r);
    logic [15:0] w;
    w = {sw, r, 1'b1};
    for (int i = 15; i >= 0; i--)
      put(w[i]);
    load(w[0]);
  endtask : send_ref
  task automatic send_div(input logic [10:0] nr, input logic [5:0] a);
    logic [18:0] w;
    w = {nr, 1'b0, a, 1'b0};
    for (int i = 18; i >= 0; i--)
      put(w[i]);
    load(w[0]);
  endtask : send_div
endmodule : spd_host_model
`default_nettype wire

// >>> verification/test_serial_pll_divider_control.sv
// Self-checking bench for the divider control block.
`timescale 1ns/1ps
`default_nettype none
module test_serial_pll_divider_control;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic phase_polarity_select = 1'b1;
  logic vco_in = 1'b0;
  logic vco_run = 1'b0;
  logic [1:0] vco_div = 2'h0;
  wire ser_clk;
  wire ser_data;
  wire load_latch_strobe;
  logic pump_out, pump_oe, ref_pd_out, vco_pd_out, vco_pd_oe;
  logic fastlock_switch_out, fastlock_switch_oe, lock_indicator_out, monitor_out;
  int miscompares = 0;
  int checks = 0;
  int n;
  always #5 clk = ~clk;
  // The VCO edge comes every 8 clocks, well inside the synchroniser margin.
  always @(posedge clk)
  begin
    vco_div <= vco_div + 2'h1;
    if (vco_run && vco_div == 2'h3)
      vco_in <= ~vco_in;
  end
  spd_host_model host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
    .load_latch_strobe(load_latch_strobe));
  spd_serial_pll_divider DUT (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .ser_clk(ser_clk), .ser_data(ser_data),
    .load_latch_strobe(load_latch_strobe), .phase_polarity_select(phase_polarity_select),
    .vco_in(vco_in), .pump_out(pump_out), .pump_oe(pump_oe), .ref_pd_out(ref_pd_out),
    .vco_pd_out(vco_pd_out), .vco_pd_oe(vco_pd_oe), .fastlock_switch_out(fastlock_switch_out),
    .fastlock_switch_oe(fastlock_switch_oe), .lock_indicator_out(lock_indicator_out),
    .monitor_out(monitor_out)
  );
  task automatic check(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : check
  task automatic next_pulse(output int k);
    k = 0;
    @(posedge clk);
    while (monitor_out !== 1'b1 && k < 20000)
    begin
      k++;
      @(posedge clk);
    end
  endtask : next_pulse
  // The first pulse may close a cycle begun with the old ratio.
  task automatic period_is(input int p);
    next_pulse(n);
    next_pulse(n);
    check(n + 1 == p, 1'b1, "period");
  endtask : period_is
  task automatic drive_is(input logic up, input logic rp, input logic vo);
    int k;
    k = 0;
    while (pump_oe !== 1'b1 && k < 20000)
    begin
      k++;
      @(posedge clk);
    end
    check(pump_oe, 1'b1, "pump drive");
    check(pump_out, up, "pump level");
    check(ref_pd_out, rp, "ref side");
    check(vco_pd_oe, vo, "vco side");
    check(lock_indicator_out, 1'b0, "lock");
  endtask : drive_is
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    check(lock_indicator_out, 1'b1, "lock at reset");
    check(pump_oe, 1'b0, "pump at reset");
    period_is(8);
    drive_is(1'b1, 1'b0, 1'b1);
    $display("test reference lead done");
    host.send_ref(1'b1, 14'h012C);
    period_is(300);
    phase_polarity_select <= 1'b0;
    repeat (4) @(posedge clk);
    drive_is(1'b0, 1'b1, 1'b0);
    $display("test ratio and polarity done");
    host.send_div(11'h010, 6'h01);
    vco_run <= 1'b1;
    period_is(4104);
    host.send_ref(1'b0, 14'h012C);
    period_is(8200);
    $display("test swallow done");
    host.send_ref(1'b1, 14'h3FFF);
    repeat (3) next_pulse(n);
    drive_is(1'b1, 1'b0, 1'b1);
    phase_polarity_select <= 1'b1;
    repeat (4) @(posedge clk);
    drive_is(1'b0, 1'b1, 1'b0);
    $display("test vco lead done");
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    check(lock_indicator_out, 1'b1, "lock at reset");
    period_is(8);
    // The wait starts six edges after the pulse; five frozen edges stretch the period.
    next_pulse(n);
    clk_en <= 1'b0;
    repeat (5) @(posedge clk);
    clk_en <= 1'b1;
    next_pulse(n);
    check(n + 6 == 8 + 5, 1'b1, "frozen period");
    $display("test second reset done");
    end_of_test();
  end
  initial
  begin
    #600000;
    miscompares++;
    end_of_test();
  end
endmodule : test_serial_pll_divider_control
`default_nettype wire
